// *** hw/npt_pkg.sv ***
// package for the napt translation engine: constants, descriptor and table types
package npt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SEC_UNIT = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_UNIT;
  localparam logic [15:0] TIMEOUT_DEF_SEC = 16'd300;
  // closing sessions keep their entry only briefly after fin
  localparam logic [15:0] CLOSE_SEC = 16'd4;

  // ----------------------------------------------------------------
  // table layout
  // ----------------------------------------------------------------
  localparam int unsigned TBL_DEPTH = 8;
  localparam int unsigned IDX_W = 3;
  localparam logic [15:0] PUB_PORT_BASE = 16'hc000;

  // ----------------------------------------------------------------
  // private ranges: 10/8, 172.16/12, 192.168/16
  // ----------------------------------------------------------------
  localparam logic [31:0] PRIV_A_NET = 32'h0a00_0000;
  localparam logic [31:0] PRIV_A_MASK = 32'hff00_0000;
  localparam logic [31:0] PRIV_B_NET = 32'hac10_0000;
  localparam logic [31:0] PRIV_B_MASK = 32'hfff0_0000;
  localparam logic [31:0] PRIV_C_NET = 32'hc0a8_0000;
  localparam logic [31:0] PRIV_C_MASK = 32'hffff_0000;

  // header fields of one packet as parsed upstream
  typedef struct packed {
    logic from_customer;
    logic [7:0] proto;
    logic [31:0] src_ip;
    logic [15:0] src_port;
    logic [31:0] dst_ip;
    logic [15:0] dst_port;
    logic icmp_err;
    logic [31:0] in_src_ip;
    logic [15:0] in_src_port;
    logic [31:0] in_dst_ip;
    logic [15:0] in_dst_port;
    logic ftp_cmd;
    logic [31:0] ftp_ip;
    logic [15:0] ftp_port;
    logic tcp_fin;
  } npt_pkt_t;

  typedef struct packed {
    logic to_operator;
    npt_pkt_t pkt;
  } npt_out_t;

  typedef struct packed {
    logic valid;
    logic [31:0] priv_ip;
    logic [15:0] priv_port;
    logic [15:0] timer;
  } npt_ent_t;

  typedef struct packed {
    logic hit;
    logic [IDX_W-1:0] idx;
  } npt_match_t;

endpackage

// *** hw/npt_engine.sv ***
// napt translation engine: mapping table, header rewrite, ageing and output buffer
`timescale 1ns/10ps

// Contract
// - many private endpoints share one public address
// - outbound private-to-public packet creates mapping
// - one private endpoint, always same public endpoint
// - inbound packets never create mappings
// - customer-to-customer traffic is not translated
// - customer side uses only private ranges
// - reverse mapping installed with forward one
// - outbound source rewritten to public endpoint
// - inbound destination restored to private endpoint
// - dynamic entries expire after timeout
// - default timeout is 300 seconds
// - timeout may be configured
// - early close allowed, timer stays as fallback
// - icmp errors: outer and inner headers translated
// - ftp helper translates data port parameters
// - operator-side packets translated before routing
module npt_engine #(
  parameter int unsigned SEC_CYCLES = npt_pkg::SEC_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // configuration
  input wire logic [31:0] pub_addr,
  input wire logic [15:0] timeout_sec,
  // packet descriptors in
  input wire logic in_valid,
  input npt_pkg::npt_pkt_t in_desc,
  output logic in_ready,
  // translated descriptors out
  output logic out_valid,
  output npt_pkg::npt_out_t out_desc,
  input wire logic out_ready,
  // status
  output logic drop_pulse,
  output logic table_full
);

  typedef struct packed {
    npt_pkg::npt_ent_t [npt_pkg::TBL_DEPTH-1:0] tbl;
    logic [31:0] sec_cnt;
    npt_pkg::npt_out_t [1:0] slot;
    logic [1:0] cnt;
    logic vld;
    logic rdy;
    logic drop;
    logic full;
  } npt_state_t;

  npt_state_t s_r;
  npt_state_t s_nxt;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // customer-side addresses are expected from these three ranges only
  function automatic logic is_private(input logic [31:0] ip);
    is_private = ((ip & npt_pkg::PRIV_A_MASK) == npt_pkg::PRIV_A_NET) ||
                 ((ip & npt_pkg::PRIV_B_MASK) == npt_pkg::PRIV_B_NET) ||
                 ((ip & npt_pkg::PRIV_C_MASK) == npt_pkg::PRIV_C_NET);
  endfunction

  function automatic logic [15:0] pub_port(input logic [npt_pkg::IDX_W-1:0] idx);
    pub_port = npt_pkg::PUB_PORT_BASE + {13'h0000, idx};
  endfunction

  function automatic npt_pkg::npt_match_t find_priv(
    input npt_pkg::npt_ent_t [npt_pkg::TBL_DEPTH-1:0] tbl,
    input logic [31:0] ip,
    input logic [15:0] port
  );
    npt_pkg::npt_match_t m;
    m = '0;
    for (int i = npt_pkg::TBL_DEPTH - 1; i >= 0; i--)
    begin
      if (tbl[i].valid && tbl[i].priv_ip == ip && tbl[i].priv_port == port)
      begin
        m.hit = 1'b1;
        m.idx = i[npt_pkg::IDX_W-1:0];
      end
    end
    find_priv = m;
  endfunction

  // the public port alone keys an inbound lookup; the caller checks the address
  function automatic npt_pkg::npt_match_t find_pub(
    input npt_pkg::npt_ent_t [npt_pkg::TBL_DEPTH-1:0] tbl,
    input logic [15:0] port
  );
    npt_pkg::npt_match_t m;
    m = '0;
    for (int i = 0; i < npt_pkg::TBL_DEPTH; i++)
    begin
      if (tbl[i].valid && pub_port(i[npt_pkg::IDX_W-1:0]) == port)
      begin
        m.hit = 1'b1;
        m.idx = i[npt_pkg::IDX_W-1:0];
      end
    end
    find_pub = m;
  endfunction

  // a full table drops new sessions; nothing is evicted early to make room
  // lowest free slot, optionally skipping one already claimed this cycle
  function automatic npt_pkg::npt_match_t find_free(
    input npt_pkg::npt_ent_t [npt_pkg::TBL_DEPTH-1:0] tbl,
    input logic skip_en,
    input logic [npt_pkg::IDX_W-1:0] skip_idx
  );
    npt_pkg::npt_match_t m;
    m = '0;
    for (int i = npt_pkg::TBL_DEPTH - 1; i >= 0; i--)
    begin
      if (!tbl[i].valid && !(skip_en && skip_idx == i[npt_pkg::IDX_W-1:0]))
      begin
        m.hit = 1'b1;
        m.idx = i[npt_pkg::IDX_W-1:0];
      end
    end
    find_free = m;
  endfunction

  // fin caps the lifetime instead of removing at once, so a late retransmit still passes
  // new lifetime of a matched entry
  function automatic logic [15:0] refresh(
    input logic [15:0] cur,
    input logic fin,
    input logic [15:0] full_to
  );
    if (fin)
      refresh = (cur > npt_pkg::CLOSE_SEC) ? npt_pkg::CLOSE_SEC : cur;
    else
      refresh = full_to;
  endfunction

  // ----------------------------------------------------------------
  // ageing, one process per entry
  // ----------------------------------------------------------------
  logic tick;
  npt_pkg::npt_ent_t aged [npt_pkg::TBL_DEPTH];

  assign tick = (s_r.sec_cnt >= SEC_CYCLES - 1);

  generate
    for (genvar g = 0; g < npt_pkg::TBL_DEPTH; g++)
    begin : age_g
      always_comb
      begin
        aged[g] = s_r.tbl[g];
        if (tick && s_r.tbl[g].valid)
        begin
          // an entry closed early by fin still runs down here as a fallback
          if (s_r.tbl[g].timer <= 16'h0001)
            aged[g].valid = 1'b0;
          else
            aged[g].timer = s_r.tbl[g].timer - 16'h0001;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [15:0] to_eff;
  logic accept;
  logic fwd;
  logic to_op;
  logic pop;
  logic [1:0] wr_pos;
  npt_pkg::npt_pkt_t d;
  npt_pkg::npt_match_t m;
  npt_pkg::npt_match_t m2;
  npt_pkg::npt_match_t f;
  npt_pkg::npt_match_t f2;

  always_comb
  begin
    s_nxt = s_r;
    d = in_desc;
    fwd = 1'b0;
    to_op = 1'b0;
    m = '0;
    m2 = '0;
    f = '0;
    f2 = '0;
    to_eff = (timeout_sec == 16'h0000) ? npt_pkg::TIMEOUT_DEF_SEC : timeout_sec;
    s_nxt.sec_cnt = tick ? 32'h0000_0000 : s_r.sec_cnt + 32'h0000_0001;
    accept = in_valid && s_r.rdy;

    // aged table first; a hit below may still revive an entry that ages out now
    for (int i = 0; i < npt_pkg::TBL_DEPTH; i++)
    begin
      s_nxt.tbl[i] = aged[i];
    end

    if (accept)
    begin
      if (in_desc.from_customer)
      begin
        if (in_desc.icmp_err)
        begin
          // error about an inbound packet: inner destination is the private endpoint
          m = find_priv(s_r.tbl, in_desc.in_dst_ip, in_desc.in_dst_port);
          if (is_private(in_desc.dst_ip))
          begin
            fwd = 1'b1;
          end
          else if (m.hit)
          begin
            d.src_ip = pub_addr;
            d.in_dst_ip = pub_addr;
            d.in_dst_port = pub_port(m.idx);
            // a refresh wins over ageing in the same cycle
            s_nxt.tbl[m.idx].valid = 1'b1;
            s_nxt.tbl[m.idx].timer = refresh(s_nxt.tbl[m.idx].timer, 1'b0, to_eff);
            fwd = 1'b1;
            to_op = 1'b1;
          end
        end
        else if (is_private(in_desc.dst_ip))
        begin
          // both ends on the customer side: routed as is, no entry
          fwd = 1'b1;
        end
        else if (is_private(in_desc.src_ip))
        begin
          // outside icmp errors, a non-private customer source is never translated
          m = find_priv(s_r.tbl, in_desc.src_ip, in_desc.src_port);
          f = find_free(s_r.tbl, 1'b0, '0);
          if (in_desc.ftp_cmd)
          begin
            m2 = find_priv(s_r.tbl, in_desc.src_ip, in_desc.ftp_port);
            f2 = find_free(s_r.tbl, !m.hit, f.idx);
          end
          // the packet goes only when every endpoint it needs has a slot
          if ((m.hit || f.hit) && (!in_desc.ftp_cmd || m2.hit || f2.hit))
          begin
            if (!m.hit)
            begin
              m.idx = f.idx;
              s_nxt.tbl[f.idx].valid = 1'b1;
              s_nxt.tbl[f.idx].priv_ip = in_desc.src_ip;
              s_nxt.tbl[f.idx].priv_port = in_desc.src_port;
            end
            s_nxt.tbl[m.idx].valid = 1'b1;
            s_nxt.tbl[m.idx].timer = refresh(s_nxt.tbl[m.idx].timer, in_desc.tcp_fin, to_eff);
            d.src_ip = pub_addr;
            d.src_port = pub_port(m.idx);
            if (in_desc.ftp_cmd)
            begin
              if (!m2.hit)
              begin
                m2.idx = f2.idx;
                s_nxt.tbl[f2.idx].valid = 1'b1;
                s_nxt.tbl[f2.idx].priv_ip = in_desc.src_ip;
                s_nxt.tbl[f2.idx].priv_port = in_desc.ftp_port;
              end
              s_nxt.tbl[m2.idx].valid = 1'b1;
              s_nxt.tbl[m2.idx].timer = to_eff;
              d.ftp_ip = pub_addr;
              d.ftp_port = pub_port(m2.idx);
            end
            fwd = 1'b1;
            to_op = 1'b1;
          end
        end
      end
      else
      begin
        // operator side is looked up first and never allocates
        if (in_desc.icmp_err)
          m = find_pub(s_r.tbl, in_desc.in_src_port);
        else
          m = find_pub(s_r.tbl, in_desc.dst_port);
        if (m.hit && in_desc.dst_ip == pub_addr &&
            (!in_desc.icmp_err || in_desc.in_src_ip == pub_addr))
        begin
          d.dst_ip = s_r.tbl[m.idx].priv_ip;
          if (in_desc.icmp_err)
          begin
            d.in_src_ip = s_r.tbl[m.idx].priv_ip;
            d.in_src_port = s_r.tbl[m.idx].priv_port;
          end
          else
          begin
            d.dst_port = s_r.tbl[m.idx].priv_port;
          end
          s_nxt.tbl[m.idx].valid = 1'b1;
          s_nxt.tbl[m.idx].timer = refresh(s_nxt.tbl[m.idx].timer, in_desc.tcp_fin, to_eff);
          fwd = 1'b1;
        end
        // no match: dropped, nothing created
      end
    end

    // two-entry output buffer, head always in slot 0
    // two places cover the stalled head plus the word accepted while ready fell
    pop = s_r.vld && out_ready;
    if (pop)
    begin
      s_nxt.slot[0] = s_r.slot[1];
    end
    wr_pos = s_r.cnt - {1'b0, pop};
    if (accept && fwd)
    begin
      s_nxt.slot[wr_pos[0]] = '{to_operator: to_op, pkt: d};
    end
    s_nxt.cnt = s_r.cnt - {1'b0, pop} + {1'b0, accept && fwd};
    s_nxt.vld = (s_nxt.cnt != 2'b00);
    // a free place is promised one cycle ahead, so a stalled receiver loses nothing
    s_nxt.rdy = (s_nxt.cnt != 2'b10);
    s_nxt.drop = accept && !fwd;
    s_nxt.full = 1'b1;
    for (int i = 0; i < npt_pkg::TBL_DEPTH; i++)
    begin
      if (!s_nxt.tbl[i].valid)
        s_nxt.full = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign in_ready = s_r.rdy;
  assign out_valid = s_r.vld;
  assign out_desc = s_r.slot[0];
  assign drop_pulse = s_r.drop;
  assign table_full = s_r.full;

endmodule

// *** test/npt_engine_props.sv ***
// port assertions for the napt translation engine
`timescale 1ns/10ps
module npt_engine_props #(
  parameter int unsigned SEC_CYCLES = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // configuration
  input wire logic [31:0] pub_addr,
  input wire logic [15:0] timeout_sec,
  // descriptors
  input wire logic in_valid,
  input wire npt_pkg::npt_pkt_t in_desc,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire npt_pkg::npt_out_t out_desc,
  input wire logic out_ready,
  // status
  input wire logic drop_pulse,
  input wire logic table_full
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  function automatic logic priv(logic [31:0] a);
    return ((a & npt_pkg::PRIV_A_MASK) == npt_pkg::PRIV_A_NET) || ((a & npt_pkg::PRIV_B_MASK) == npt_pkg::PRIV_B_NET)
      || ((a & npt_pkg::PRIV_C_MASK) == npt_pkg::PRIV_C_NET);
  endfunction

  // ----------------------------------------
  // properties
  // ----------------------------------------
  drop_silent_a: assert property (drop_pulse && !$past(out_valid) |-> !out_valid)
    else $error("dropped descriptor reached the output");
  drop_cause_a: assert property (drop_pulse |-> $past(in_valid) && $past(in_ready))
    else $error("drop without accepted descriptor");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_desc))
    else $error("output changed while stalled");
  src_public_a: assert property (out_valid && out_desc.to_operator |-> out_desc.pkt.src_ip == pub_addr)
    else $error("outbound source not public");
  port_pool_a: assert property (out_valid && out_desc.to_operator && !out_desc.pkt.icmp_err
    |-> out_desc.pkt.src_port[15:3] == 13'h1800)
    else $error("outbound port outside pool");
  dst_private_a: assert property (out_valid && !out_desc.to_operator |-> priv(out_desc.pkt.dst_ip))
    else $error("customer bound destination not private");
  answer_time_a: assert property (in_valid && in_ready && !out_valid |=> out_valid || drop_pulse)
    else $error("no answer one cycle after accept");
  icmp_inner_a: assert property (out_valid && !out_desc.to_operator && out_desc.pkt.icmp_err
    && !out_desc.pkt.from_customer |-> priv(out_desc.pkt.in_src_ip))
    else $error("inner source not restored");
endmodule

bind npt_engine npt_engine_props #(.SEC_CYCLES(SEC_CYCLES)) chk_u (.clk_sys(clk_sys), .resetn(resetn),
  .pub_addr(pub_addr), .timeout_sec(timeout_sec), .in_valid(in_valid), .in_desc(in_desc), .in_ready(in_ready),
  .out_valid(out_valid), .out_desc(out_desc), .out_ready(out_ready), .drop_pulse(drop_pulse),
  .table_full(table_full));

// *** test/npt_sink.sv ***
// receiver model at the engine output: stalls on request, records each word taken
`timescale 1ns/10ps
module npt_sink (
  // clock
  input wire logic clk_sys,
  // stream from the engine
  input wire logic out_valid,
  input wire npt_pkg::npt_out_t out_desc,
  output logic out_ready,
  // control and capture
  input wire logic stall,
  output int unsigned n_got,
  output npt_pkg::npt_out_t last_got
);
  assign out_ready = !stall;
  initial
  begin
    n_got = 0;
    forever
    begin
      @(posedge clk_sys);
      if (out_valid && out_ready)
      begin
        n_got <= n_got + 1;
        last_got <= out_desc;
      end
    end
  end
endmodule

// *** test/tb.sv ***
// self-checking bench for the napt translation engine
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] PA = 32'h6440_0001;
  localparam logic [31:0] SV = 32'h0808_0808;
  localparam logic [31:0] H5 = 32'h0a00_0005;
  logic clk_sys, resetn, in_valid, in_ready, out_valid, out_ready, stall, drop_pulse, table_full;
  logic [31:0] pub_addr;
  logic [15:0] timeout_sec, p;
  npt_pkg::npt_pkt_t in_desc, d;
  npt_pkg::npt_out_t out_desc, got, last_got;
  int unsigned n_got, seen, err_total, tests_run;

  npt_engine #(.SEC_CYCLES(10)) dut_u (.clk_sys(clk_sys), .resetn(resetn), .pub_addr(pub_addr),
    .timeout_sec(timeout_sec), .in_valid(in_valid), .in_desc(in_desc), .in_ready(in_ready), .out_valid(out_valid),
    .out_desc(out_desc), .out_ready(out_ready), .drop_pulse(drop_pulse), .table_full(table_full));
  npt_sink sink_u (.clk_sys(clk_sys), .out_valid(out_valid), .out_desc(out_desc), .out_ready(out_ready),
    .stall(stall), .n_got(n_got), .last_got(last_got));

  initial
  begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  function automatic npt_pkg::npt_pkt_t mk(logic c, logic [31:0] si, logic [15:0] sp, logic [31:0] di,
    logic [15:0] dp);
    npt_pkg::npt_pkt_t r;
    r = '0;
    r.from_customer = c;
    r.proto = 8'h11;
    r.src_ip = si;
    r.src_port = sp;
    r.dst_ip = di;
    r.dst_port = dp;
    return r;
  endfunction

  task automatic snd(npt_pkg::npt_pkt_t x);
    int i;
    @(posedge clk_sys);
    in_desc <= x;
    in_valid <= 1'b1;
    for (i = 0; i < 80; i++)
    begin
      @(negedge clk_sys);
      if (in_ready === 1'b1)
        break;
    end
    chk("in_ready", 1, in_ready);
    if (in_ready !== 1'b1)
      end_sim();
    @(posedge clk_sys);
    in_valid <= 1'b0;
  endtask

  task automatic take();
    int i;
    for (i = 0; i < 80 && n_got == seen; i++)
      @(negedge clk_sys);
    chk("output word", 1, n_got != seen);
    if (n_got == seen)
      end_sim();
    seen = n_got;
    got = last_got;
  endtask

  task automatic drop_chk();
    int i;
    logic hit;
    hit = 0;
    for (i = 0; i < 3; i++)
    begin
      @(negedge clk_sys);
      hit = hit | (drop_pulse === 1'b1);
    end
    chk("drop_pulse", 1, hit);
    chk("output count", seen, n_got);
  endtask

  task automatic out_port(logic [31:0] h, logic [15:0] sp, logic [15:0] e);
    snd(mk(1, h, sp, SV, 16'h0035));
    take();
    chk("to_operator", 1, got.to_operator);
    chk("src_ip", PA, got.pkt.src_ip);
    chk("src_port", e, got.pkt.src_port);
    chk("dst_ip", SV, got.pkt.dst_ip);
  endtask

  task automatic back(logic [15:0] pp, logic [31:0] h, logic [15:0] sp);
    snd(mk(0, SV, 16'h0035, PA, pp));
    take();
    chk("to_operator", 0, got.to_operator);
    chk("dst_ip", h, got.pkt.dst_ip);
    chk("dst_port", sp, got.pkt.dst_port);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_map();
    out_port(H5, 16'h03e8, 16'hc000);
    out_port(32'h0a00_0006, 16'h03e8, 16'hc001);
    out_port(H5, 16'h03e8, 16'hc000);
    back(16'hc000, H5, 16'h03e8);
  endtask

  task automatic t_refuse();
    snd(mk(0, SV, 16'h0035, PA, 16'hc005));
    drop_chk();
    snd(mk(0, SV, 16'h0035, PA, 16'hc005));
    drop_chk();
    snd(mk(1, H5, 16'h03e8, 32'hc0a8_0102, 16'h0050));
    take();
    chk("to_operator", 0, got.to_operator);
    chk("dst_ip", 32'hc0a8_0102, got.pkt.dst_ip);
    out_port(32'h0a00_0007, 16'h03e8, 16'hc002);
  endtask

  task automatic t_alg();
    d = mk(0, 32'h0808_0101, 16'h0000, PA, 16'h0000);
    d.proto = 8'h01;
    d.icmp_err = 1'b1;
    d.in_src_ip = PA;
    d.in_src_port = 16'hc000;
    d.in_dst_ip = SV;
    d.in_dst_port = 16'h0035;
    snd(d);
    take();
    chk("to_operator", 0, got.to_operator);
    chk("dst_ip", H5, got.pkt.dst_ip);
    chk("in_src_ip", H5, got.pkt.in_src_ip);
    chk("in_src_port", 16'h03e8, got.pkt.in_src_port);
    d = mk(1, H5, 16'h03e9, SV, 16'h0015);
    d.ftp_cmd = 1'b1;
    d.ftp_ip = H5;
    d.ftp_port = 16'h07d0;
    snd(d);
    take();
    chk("ftp_ip", PA, got.pkt.ftp_ip);
    chk("src_port", 16'hc003, got.pkt.src_port);
    chk("ftp_port", 16'hc004, got.pkt.ftp_port);
  endtask

  task automatic t_stall();
    stall <= 1'b1;
    snd(mk(1, H5, 16'h03e8, SV, 16'h0035));
    snd(mk(1, 32'h0a00_0006, 16'h03e8, SV, 16'h0035));
    @(negedge clk_sys);
    chk("in_ready full", 0, in_ready);
    fork
      snd(mk(1, 32'h0a00_0007, 16'h03e8, SV, 16'h0035));
    join_none
    repeat (4) @(posedge clk_sys);
    stall <= 1'b0;
    take();
    chk("order 0", 16'hc000, got.pkt.src_port);
    take();
    chk("order 1", 16'hc001, got.pkt.src_port);
    take();
    chk("order 2", 16'hc002, got.pkt.src_port);
  endtask

  task automatic t_age();
    out_port(32'h0a00_0008, 16'h03e8, 16'hc005);
    repeat (2900) @(posedge clk_sys);
    back(16'hc005, 32'h0a00_0008, 16'h03e8);
    repeat (2900) @(posedge clk_sys);
    back(16'hc005, 32'h0a00_0008, 16'h03e8);
    repeat (3050) @(posedge clk_sys);
    snd(mk(0, SV, 16'h0035, PA, 16'hc005));
    drop_chk();
    @(posedge clk_sys);
    timeout_sec <= 16'h0003;
    snd(mk(1, H5, 16'h03e8, SV, 16'h0035));
    take();
    p = got.pkt.src_port;
    repeat (45) @(posedge clk_sys);
    snd(mk(0, SV, 16'h0035, PA, p));
    drop_chk();
  endtask

  task automatic t_full();
    @(negedge clk_sys);
    chk("table_full", 0, table_full);
    @(posedge clk_sys);
    timeout_sec <= 16'h0000;
    for (int k = 0; k < 8; k++)
      out_port(32'h0a00_0100 + 32'(k), 16'h03e8, 16'hc000 + 16'(k));
    @(negedge clk_sys);
    chk("table_full", 1, table_full);
    snd(mk(1, 32'h0a00_0200, 16'h03e8, SV, 16'h0035));
    drop_chk();
  endtask

  initial
  begin
    resetn = 0;
    in_valid = 0;
    in_desc = '0;
    stall = 0;
    pub_addr = PA;
    timeout_sec = 16'h0000;
    seen = 0;
    err_total = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    t_map();
    t_refuse();
    t_alg();
    t_stall();
    t_age();
    t_full();
    end_sim();
  end
endmodule
